// [rtl/panel_supply_startup_sequencer.sv]
/*
  Start-up sequencer, fault latch and slice multiplexer control for a panel
  supply device. Assumes the delay ramp generator, comparators and thermal
  sensor are outside and deliver synchronous single-bit levels and pulses.
*/
`timescale 1ns/100ps
module panel_supply_startup_sequencer #(
  parameter int unsigned DELAY_CAP_NF = panel_seq_pkg::NOMINAL_DELAY_CAP_NF,
  parameter int unsigned TIMEOUT_CYCLES =
    panel_seq_pkg::FAULT_TIMEOUT_CYCLES_NOM * DELAY_CAP_NF / panel_seq_pkg::NOMINAL_DELAY_CAP_NF
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic ENABLE,
  input wire logic SUPPLY_OK,
  input wire logic RAMP_START,
  input wire logic RAMP_PEAK,
  input wire panel_seq_pkg::fault_in_t FAULTS,
  input wire logic SLICE_SELECT,
  output panel_seq_pkg::rail_en_t RAILS,
  output logic RAMP_CHARGE,
  output logic RAMP_DISCHARGE,
  output panel_seq_pkg::slice_sw_t SLICE_SW,
  output logic STARTUP_DONE,
  output logic LATCHED_OFF
);
  import panel_seq_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [2:0] peak_cnt_q;
  logic early_seen_q;
  logic boost_checked_q;
  logic run_ok;
  logic ramping;
  logic peak_ev;
  logic start_ev;
  logic check_trip;
  logic mon_fault;
  logic timeout_hit;
  logic fault_trip;

  // Number of the ramp that is now charging, or of the peak about to come
  function automatic logic [2:0] next_step(input logic [2:0] peaks);
    next_step = peaks + PEAK_STEP;
  endfunction

  assign run_ok = ENABLE && SUPPLY_OK;
  assign ramping = (state_q == ST_RAMP);
  assign peak_ev = ramping && RAMP_PEAK; // RULE_16
  assign start_ev = ramping && RAMP_START; // RULE_16

  // Checks made at the end of a ramp, that is at its peak
  always_comb begin
    check_trip = 1'b0;
    if (peak_ev) begin
      case (next_step(peak_cnt_q))
        PEAK_REF_ON: check_trip = early_seen_q || FAULTS.early_fault; // RULE_04
        PEAK_BOOST_CHECK: check_trip = FAULTS.boost_fault; // RULE_07
        PEAKS_FOR_DONE: check_trip = FAULTS.pos_uv || FAULTS.neg_uv; // RULE_09 RULE_15
        default: check_trip = 1'b0;
      endcase
    end
  end

  // Supplies that already passed their check are watched for lasting faults
  assign mon_fault = (boost_checked_q && FAULTS.boost_fault) ||
                     ((state_q == ST_RUN) && (FAULTS.pos_uv || FAULTS.neg_uv)); // RULE_15

  fault_timeout_timer #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_timeout (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .active(mon_fault),
    .expired(timeout_hit)
  );

  assign fault_trip = check_trip || timeout_hit || FAULTS.over_temp; // RULE_02 RULE_10 RULE_14

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (run_ok) begin
          state_d = ST_RAMP; // RULE_03
        end
      end
      ST_RAMP: begin
        if (!run_ok) begin
          state_d = ST_OFF;
        end else if (fault_trip) begin
          state_d = ST_LATCHED; // RULE_04
        end else if (peak_ev && (next_step(peak_cnt_q) == PEAKS_FOR_DONE)) begin
          state_d = ST_RUN; // RULE_01
        end
      end
      ST_RUN: begin
        if (!run_ok) begin
          state_d = ST_OFF;
        end else if (fault_trip) begin
          state_d = ST_LATCHED; // RULE_02
        end
      end
      ST_LATCHED: begin
        // Only a drop of enable or supply unlocks; a fault clearing does not
        if (!run_ok) begin
          state_d = ST_OFF; // RULE_02 RULE_14
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      peak_cnt_q <= PEAK_CNT_RESET;
    end else if (state_d == ST_OFF) begin
      peak_cnt_q <= PEAK_CNT_RESET;
    end else if (peak_ev && (peak_cnt_q != PEAKS_FOR_DONE)) begin
      peak_cnt_q <= next_step(peak_cnt_q); // RULE_01 RULE_16
    end
  end

  // Early faults seen any time during the first slow ramp are remembered for its peak
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      early_seen_q <= 1'b0;
    end else if (ramping && (peak_cnt_q == PEAK_CNT_RESET) && FAULTS.early_fault) begin
      early_seen_q <= 1'b1; // RULE_04
    end else if (state_q == ST_OFF) begin
      early_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      boost_checked_q <= 1'b0;
    end else if ((state_d == ST_OFF) || (state_d == ST_LATCHED)) begin
      boost_checked_q <= 1'b0;
    end else if (peak_ev && (next_step(peak_cnt_q) == PEAK_BOOST_CHECK)) begin
      boost_checked_q <= 1'b1; // RULE_07
    end
  end

  // Supply enables; all drop together on a latch so no rail is left alone
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RAILS <= RAILS_OFF;
    end else if ((state_d == ST_OFF) || (state_d == ST_LATCHED)) begin
      RAILS <= RAILS_OFF; // RULE_02 RULE_14
    end else begin
      if (peak_ev && (next_step(peak_cnt_q) == PEAK_REF_ON)) begin
        RAILS.reference <= 1'b1; // RULE_05
      end
      if (start_ev && (next_step(peak_cnt_q) == RAMP_BOOST_START)) begin
        RAILS.boost <= 1'b1; // RULE_06 RULE_07
      end
      if (peak_ev && (next_step(peak_cnt_q) == PEAK_NEG_ON)) begin
        RAILS.neg_gate <= 1'b1; // RULE_08
      end
      if (start_ev && (next_step(peak_cnt_q) == RAMP_POS_START)) begin
        RAILS.pos_gate <= 1'b1; // RULE_09
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RAMP_CHARGE <= 1'b0;
    end else begin
      RAMP_CHARGE <= (state_d == ST_RAMP); // RULE_03
    end
  end

  // One-cycle discharge after every clean peak except the last
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RAMP_DISCHARGE <= 1'b0;
    end else begin
      RAMP_DISCHARGE <= peak_ev && (state_d == ST_RAMP); // RULE_04
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      STARTUP_DONE <= 1'b0;
      LATCHED_OFF <= 1'b0;
    end else begin
      STARTUP_DONE <= (state_d == ST_RUN); // RULE_01
      LATCHED_OFF <= (state_d == ST_LATCHED); // RULE_02
    end
  end

  // Break before make is left to the analog switches; only one enable is ever high
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SLICE_SW <= SLICE_GROUNDED;
    end else if (state_d != ST_RUN) begin
      SLICE_SW <= SLICE_GROUNDED; // RULE_11
    end else begin
      SLICE_SW.to_ground <= 1'b0;
      SLICE_SW.to_high_rail <= !SLICE_SELECT; // RULE_12
      SLICE_SW.to_low_rail <= SLICE_SELECT; // RULE_13
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  done_after_six_a: assert property ($rose(STARTUP_DONE) |-> // RULE_01
    $past(RAMP_PEAK) && ($past(peak_cnt_q) == 3'h5))
    else $error("start-up done without the sixth peak");

  latch_holds_off_a: assert property (LATCHED_OFF && ENABLE && SUPPLY_OK |=> // RULE_02
    LATCHED_OFF && (RAILS == RAILS_OFF))
    else $error("latch released or rail on while enabled");

  ramp_needs_supply_a: assert property ($rose(RAMP_CHARGE) |-> // RULE_03
    $past(SUPPLY_OK) && $past(ENABLE))
    else $error("ramp started without supply");

  first_peak_check_a: assert property (RAMP_CHARGE && RAMP_PEAK && // RULE_04
    (peak_cnt_q == 3'h0) && FAULTS.early_fault |=> LATCHED_OFF)
    else $error("early fault did not latch at first peak");

  ref_on_peak_a: assert property ($rose(RAILS.reference) |-> // RULE_05
    $past(RAMP_PEAK) && ($past(peak_cnt_q) == 3'h0))
    else $error("reference enabled off the first peak");

  boost_held_off_a: assert property (RAILS.boost |-> (peak_cnt_q >= 3'h2)) // RULE_06
    else $error("boost enabled within the first two ramps");

  boost_start_a: assert property ($rose(RAILS.boost) |-> // RULE_07
    $past(RAMP_START) && ($past(peak_cnt_q) == 3'h2))
    else $error("boost soft-start not at third ramp");

  neg_on_peak_a: assert property ($rose(RAILS.neg_gate) |-> // RULE_08
    $past(RAMP_PEAK) && ($past(peak_cnt_q) == 3'h3))
    else $error("negative gate supply not at fourth peak");

  pos_on_ramp_a: assert property ($rose(RAILS.pos_gate) |-> // RULE_09
    $past(RAMP_START) && ($past(peak_cnt_q) == 3'h5))
    else $error("positive gate supply not at sixth ramp");

  slice_grounded_a: assert property (!STARTUP_DONE |-> (SLICE_SW == SLICE_GROUNDED)) // RULE_11
    else $error("slice output left ground during start-up");

  slice_high_rail_a: assert property (STARTUP_DONE && $past(STARTUP_DONE) && // RULE_12
    !$past(SLICE_SELECT) |-> SLICE_SW.to_high_rail && !SLICE_SW.to_low_rail)
    else $error("low select did not pick high rail");

  slice_low_rail_a: assert property (STARTUP_DONE && $past(STARTUP_DONE) && // RULE_13
    $past(SLICE_SELECT) |-> SLICE_SW.to_low_rail && !SLICE_SW.to_high_rail)
    else $error("high select did not pick low rail");

  thermal_latch_a: assert property ((RAMP_CHARGE || STARTUP_DONE) && // RULE_14
    FAULTS.over_temp && ENABLE && SUPPLY_OK |=> LATCHED_OFF [*2])
    else $error("over-temperature did not latch off");

  discharge_pulse_a: assert property (RAMP_DISCHARGE |=> !RAMP_DISCHARGE) // RULE_04
    else $error("discharge held longer than one cycle");

  done_all_rails_a: assert property (STARTUP_DONE |-> // RULE_01
    RAILS.reference && RAILS.boost && RAILS.neg_gate && RAILS.pos_gate && !RAMP_CHARGE)
    else $error("start-up done with a rail off or ramp charging");

  latch_release_a: assert property (LATCHED_OFF && !ENABLE |=> // RULE_02
    !LATCHED_OFF && !RAMP_CHARGE && (RAILS == RAILS_OFF))
    else $error("enable drop did not release the latch");

  boost_check_a: assert property (RAMP_CHARGE && RAMP_PEAK && (peak_cnt_q == 3'h2) && // RULE_07
    FAULTS.boost_fault && ENABLE && SUPPLY_OK |=> LATCHED_OFF)
    else $error("boost fault at third peak did not latch");

  timeout_latch_a: assert property ((RAMP_CHARGE || STARTUP_DONE) && timeout_hit && // RULE_10
    ENABLE && SUPPLY_OK |=> LATCHED_OFF)
    else $error("expired time-out did not latch off");

  slice_onehot_a: assert property ($onehot(SLICE_SW)) // RULE_12
    else $error("slice switch enables not one-hot");

  gate_check_a: assert property (RAMP_CHARGE && RAMP_PEAK && (peak_cnt_q == 3'h5) && // RULE_09
    (FAULTS.pos_uv || FAULTS.neg_uv) && ENABLE && SUPPLY_OK |=> LATCHED_OFF && !STARTUP_DONE)
    else $error("gate supply fault at sixth peak did not latch");

endmodule

// [rtl/panel_seq_pkg.sv]
/*
  Constants, field layouts and state encoding for the panel supply start-up
  sequencer. Assumes a single 40 MHz reference clock and analog comparators
  whose outputs arrive already synchronous to it.
*/
// How it works
// RULE_01 - Start-up counts as complete only after six delay ramp peaks, each peak being one step.
// RULE_02 - Any fault latches every output off until enable drops or the supply goes away.
// RULE_03 - The delay ramp starts charging only once the supply is above its start threshold.
// RULE_04 - Faults are checked over the first ramp; clean means discharge and go on, else latch.
// RULE_05 - The reference output turns on at the first peak.
// RULE_06 - The boost stays off through the first two ramps.
// RULE_07 - Boost soft-start begins with the third ramp and its output is checked at that ramp's end.
// RULE_08 - The negative gate supply turns on at the fourth peak.
// RULE_09 - The positive gate supply turns on with the sixth ramp; both gate supplies are checked at its end.
// RULE_10 - A fault that persists past a time-out, 50 ms scaled by the delay capacitor, latches off.
// RULE_11 - During start-up the slice output is held at ground whatever the select input says.
// RULE_12 - After start-up a low select connects the slice output to the high rail input.
// RULE_13 - After start-up a high select connects the slice output to the low rail input.
// RULE_14 - Over-temperature latches off until the supply or enable is cycled.
// RULE_15 - The positive gate undervoltage comparator output is taken in as a fault input.
// RULE_16 - Ramp events and comparator outputs are synchronous single bits; peaks drive a stage counter.
package panel_seq_pkg;

  localparam logic [2:0] PEAK_CNT_RESET = 3'h0;
  localparam logic [2:0] PEAK_STEP = 3'h1;
  localparam logic [2:0] PEAK_REF_ON = 3'h1;
  localparam logic [2:0] RAMP_BOOST_START = 3'h3;
  localparam logic [2:0] PEAK_BOOST_CHECK = 3'h3;
  localparam logic [2:0] PEAK_NEG_ON = 3'h4;
  localparam logic [2:0] RAMP_POS_START = 3'h6;
  localparam logic [2:0] PEAKS_FOR_DONE = 3'h6;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FAULT_TIMEOUT_MS = 50;
  localparam int unsigned NOMINAL_DELAY_CAP_NF = 220;
  localparam int unsigned FAULT_TIMEOUT_CYCLES_NOM = (CLK_HZ / 1000) * FAULT_TIMEOUT_MS;

  typedef struct packed {
    logic over_temp;
    logic pos_uv;
    logic neg_uv;
    logic boost_fault;
    logic early_fault;
  } fault_in_t;

  typedef struct packed {
    logic reference;
    logic boost;
    logic neg_gate;
    logic pos_gate;
  } rail_en_t;

  typedef struct packed {
    logic to_ground;
    logic to_high_rail;
    logic to_low_rail;
  } slice_sw_t;

  localparam rail_en_t RAILS_OFF = 4'h0;
  localparam slice_sw_t SLICE_GROUNDED = 3'h4;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RAMP,
    ST_RUN,
    ST_LATCHED
  } seq_state_t;

endpackage

// [rtl/fault_timeout_timer.sv]
/*
  Persistence timer for supply faults after they have passed their start-up
  check. Assumes the fault level is synchronous to the clock.
*/
`timescale 1ns/100ps
module fault_timeout_timer #(
  parameter int unsigned CYCLES = 2_000_000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  output logic expired
);
  import panel_seq_pkg::*;

  localparam logic [31:0] LIMIT = 32'(CYCLES - 1);

  logic [31:0] cnt_q;

  // Any gap in the fault restarts the wait, so glitches never add up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else if (!active) begin
      cnt_q <= 32'h0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= active && (cnt_q == LIMIT); // RULE_10
    end
  end

  no_early_expiry_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    !active |=> !expired) else $error("timeout expired without a persisting fault");

endmodule

// [sim/ramp_model.sv]
/*
  Behavioural delay ramp generator facing the sequencer.
  Assumes charge and discharge come straight from the sequencer's registered outputs.
*/
`timescale 1ns/100ps
module ramp_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic charge,
  input wire logic discharge,
  input wire logic [3:0] gap,
  output logic start,
  output logic peak
);
  logic [3:0] cnt_q;
  logic rising_q;
  logic armed_q;

  // One-cycle event pulses, never both at once
  always_ff @(posedge clk) begin
    start <= 1'b0;
    peak <= 1'b0;
    if (!rst_n || !charge) begin
      cnt_q <= 4'h0;
      rising_q <= 1'b1;
      armed_q <= 1'b1;
    end else if (discharge) begin
      // A new ramp opens with a start event, the first ramp has none
      cnt_q <= 4'h0;
      rising_q <= 1'b0;
      armed_q <= 1'b1;
    end else if (armed_q) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q + 4'h1 >= gap) begin
        cnt_q <= 4'h0;
        if (rising_q) begin
          peak <= 1'b1;
          armed_q <= 1'b0;
        end else begin
          start <= 1'b1;
          rising_q <= 1'b1;
        end
      end
    end
  end
endmodule

// [sim/testbench.sv]
/*
  Self-checking bench for the panel supply start-up sequencer.
  Assumes ramp_model on the far side and a shortened fault time-out.
*/
`timescale 1ns/100ps
module testbench;
  import panel_seq_pkg::*;
  localparam int unsigned TMO = 16;
  logic clk, rst_n, en, sok, sel, rs, rp, chg, dis, done, lat;
  logic [3:0] gap;
  fault_in_t flt;
  rail_en_t rails;
  slice_sw_t sw;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd92847;

  panel_supply_startup_sequencer #(.TIMEOUT_CYCLES(TMO)) DUT (.REF_CLK(clk), .RST_N(rst_n),
    .ENABLE(en), .SUPPLY_OK(sok), .RAMP_START(rs), .RAMP_PEAK(rp), .FAULTS(flt),
    .SLICE_SELECT(sel), .RAILS(rails), .RAMP_CHARGE(chg), .RAMP_DISCHARGE(dis),
    .SLICE_SW(sw), .STARTUP_DONE(done), .LATCHED_OFF(lat));
  ramp_model model (.clk(clk), .rst_n(rst_n), .charge(chg), .discharge(dis), .gap(gap),
    .start(rs), .peak(rp));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic slice_sw_t slice_for(input logic s);
    return s ? 3'h1 : 3'h2;
  endfunction

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  // Fault bit fb > 0 is raised once the peak count reaches at_p, bit 0 on the first cycle only; fb < 0 runs clean
  task automatic startup(input int fb, input int at_p);
    int p, n;
    logic b, g, pend, dis_e, early;
    fault_in_t f;
    p = 0; n = 0; b = 0; g = 0; pend = 0; dis_e = 0; early = 0; f = '0;
    @(posedge clk);
    en <= 1'b1;
    sok <= 1'b1;
    gap <= 4'(xs() % 7 + 1);
    while (n < 300) begin
      @(posedge clk);
      flt <= f;
      sel <= xs() % 2;
      @(negedge clk);
      n++;
      if (pend) begin
        chk(lat === 1'b1 && rails === RAILS_OFF && chg === 1'b0, "no latch");
        break;
      end
      chk(lat === 1'b0 && dis === dis_e && chg === (p < 6), "ramp control");
      chk(rails === {p >= 1, b, p >= 4, g}, "rail order");
      chk(done === (p == 6), "done flag");
      if (p < 6) chk(sw === SLICE_GROUNDED, "slice not grounded");
      if (p == 6) break;
      dis_e = 0;
      early |= flt.early_fault;
      if (flt.over_temp) pend = 1;
      if (rp) begin
        if (p == 0 && early) pend = 1;
        if (p == 2 && flt.boost_fault) pend = 1;
        if (p == 5 && (flt.pos_uv || flt.neg_uv)) pend = 1;
        if (!pend && p < 5) dis_e = 1;
        p++;
      end
      if (rs && p == 2) b = 1;
      if (rs && p == 5) g = 1;
      f = '0;
      // The early fault is a one-cycle blip that must still be remembered
      if (fb == 0) f.early_fault = (n == 1);
      else if (fb > 0 && p == at_p) f[fb] = 1'b1;
    end
    chk(pend || p == 6, "sequence stalled");
    @(posedge clk);
    flt <= '0;
    $display("startup fault %0d at %0d done", fb, at_p);
  endtask

  task automatic release_latch(input logic by_en);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(lat === 1'b1, "latch let go early");
    @(posedge clk);
    if (by_en) en <= 1'b0;
    else sok <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(lat === 1'b0 && rails === RAILS_OFF, "latch held");
  endtask

  initial begin
    logic ps;
    int fbs[5] = '{0, 1, 4, 3, 2};
    int aps[5] = '{0, 2, 3, 5, 5};
    rst_n = 1'b0; en = 1'b0; sok = 1'b0; sel = 1'b0; flt = '0; gap = 4'h3;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(rails === RAILS_OFF && sw === SLICE_GROUNDED && lat === 1'b0, "reset");
    @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      chk(chg === 1'b0, "ramp before supply");
    end
    startup(-1, 0);
    ps = sel;
    repeat (24) begin
      @(posedge clk);
      sel <= xs() % 2;
      @(negedge clk);
      chk(sw === slice_for(ps), "slice mux");
      ps = sel;
    end
    @(posedge clk);
    flt <= 5'h04;
    repeat (8) @(posedge clk);
    flt <= '0;
    @(posedge clk);
    flt <= 5'h08;
    repeat (TMO) begin
      @(negedge clk);
      chk(lat === 1'b0, "time-out too soon");
    end
    repeat (3) @(negedge clk);
    chk(lat === 1'b1 && done === 1'b0, "time-out missing");
    @(posedge clk);
    flt <= '0;
    release_latch(1'b1);
    for (int i = 0; i < 5; i++) begin
      startup(fbs[i], aps[i]);
      release_latch(i % 2 == 0);
    end
    startup(-1, 0);
    @(posedge clk);
    flt <= 5'h10;
    @(posedge clk);
    @(negedge clk);
    chk(lat === 1'b1 && rails === RAILS_OFF, "hot run");
    @(posedge clk);
    flt <= '0;
    release_latch(1'b0);
    summarize();
  end
endmodule
